/* File: testbench/dual_slope_pwm_timer16_tb_top.sv */
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module dual_slope_pwm_timer16_tb_top;
  typedef struct packed {
    logic [3:0] wave;
    logic [2:0] cs;
    logic [15:0] div;
    logic [1:0] om;
    logic [15:0] cmpb;
  } pwm_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, out_a, oe_a, out_b, oe_b, pin_a, pin_b;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int tests_run = 0;
  int hi, lo, per, n, top, k;
  logic [15:0] prev;
  logic [15:0] seq [7] = '{16'h1, 16'h2, 16'h3, 16'h2, 16'h1, 16'h0, 16'h1};
  pwm_row_t rows [7] = '{
    '{4'h9, 3'h1, 16'h1, pwm_timer_pkg::OUT_NONINV, 16'h1},
    '{4'h9, 3'h2, 16'h8, pwm_timer_pkg::OUT_INV, 16'h1},
    '{4'h8, 3'h3, 16'h40, pwm_timer_pkg::OUT_NONINV, 16'h2},
    '{4'ha, 3'h1, 16'h1, pwm_timer_pkg::OUT_INV, 16'h2},
    '{4'hb, 3'h4, 16'h100, pwm_timer_pkg::OUT_NONINV, 16'h1},
    '{4'h9, 3'h5, 16'h400, pwm_timer_pkg::OUT_NONINV, 16'h2},
    '{4'h1, 3'h1, 16'h1, pwm_timer_pkg::OUT_NONINV, 16'h1}};
  logic [11:0] masks [4] = '{{8'h08, 4'h1}, {8'h08, 4'h2}, {8'h0c, 4'h3}, {8'h08, 4'h9}};
  logic [15:0] mexp [4] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'hffff};

  always #50 clk = ~clk;

  dual_slope_pwm_timer16 dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_compare_output_a(out_a), .o_compare_output_a_oe(oe_a),
    .o_compare_output_b(out_b), .o_compare_output_b_oe(oe_b)
  );
  pin_load load_a (.i_clk(clk), .i_level(out_a), .i_oe(oe_a), .o_pin(pin_a));
  pin_load load_b (.i_clk(clk), .i_level(out_b), .i_oe(oe_b), .o_pin(pin_b));

  ////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      c++;
    end while (pready !== 1'b1 && c < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(logic [3:0] w, logic [1:0] oa, logic [1:0] ob, logic [2:0] cs, logic db);
    pwm_timer_pkg::ctrl_t c;
    c.waveform_mode_field = w;
    c.output_mode_field_a = oa;
    c.output_mode_field_b = ob;
    c.clock_select = cs;
    c.pin_direction_a = 1'b1;
    c.pin_direction_b = db;
    return {19'h0, c};
  endfunction

  task setup(input logic [3:0] w, input logic [1:0] oa, input logic [1:0] ob, input logic [2:0] cs,
             input logic [15:0] cb);
    apb(1'b1, pwm_timer_pkg::OFF_CMP_A, 32'h3);
    apb(1'b1, pwm_timer_pkg::OFF_CAPTURE, 32'h3);
    apb(1'b1, pwm_timer_pkg::OFF_CMP_B, {16'h0, cb});
    apb(1'b1, pwm_timer_pkg::OFF_COUNT, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(w, oa, ob, cs, 1'b1));
  endtask

  task wait_pin(input logic a, input logic v, output int cnt);
    cnt = 0;
    while (((a ? pin_a : pin_b) !== v) && cnt < 8000) begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= 8000) begin
      mismatches++;
      give_verdict;
    end
  endtask

  task measure(input logic a);
    wait_pin(a, 1'b1, n);
    wait_pin(a, 1'b0, n);
    wait_pin(a, 1'b1, n);
    wait_pin(a, 1'b0, hi);
    wait_pin(a, 1'b1, lo);
    per = hi + lo;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    `CHK("oe_a after reset", 1'b0, oe_a)
    `CHK("out_b after reset", 1'b0, out_b)
    apb(1'b0, pwm_timer_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, pwm_timer_pkg::OFF_FLAGS, 32'h0);
    `CHK("flags reset", 32'h0, rd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(masks[i][3:0], 2'h0, 2'h0, 3'h0, 1'b1));
      apb(1'b1, masks[i][11:4], 32'hffff);
      apb(1'b0, masks[i][11:4], 32'h0);
      `CHK("compare mask", {16'h0, mexp[i]}, rd)
    end
    for (int i = 0; i < 7; i++) begin
      top = (rows[i].wave == pwm_timer_pkg::WAVE_PC_8BIT) ? int'(pwm_timer_pkg::TOP_8BIT) : 3;
      setup(rows[i].wave, rows[i].om, rows[i].om, rows[i].cs, rows[i].cmpb);
      measure(1'b0);
      `CHK("pwm period", 2 * rows[i].div * top, per)
      `CHK("pwm high", (rows[i].om == pwm_timer_pkg::OUT_INV) ? per - 2 * rows[i].div * rows[i].cmpb :
                       2 * rows[i].div * rows[i].cmpb, hi)
    end
    // extremes give a steady level
    for (int i = 0; i < 3; i++) begin
      setup(4'h9, 2'h0, (i == 2) ? pwm_timer_pkg::OUT_INV : pwm_timer_pkg::OUT_NONINV, 3'h1, (i == 1) ? 16'h3 : 16'h0);
      repeat (20) @(posedge clk);
      k = 0;
      repeat (24) begin
        @(posedge clk);
        k += (pin_b !== (i != 0));
      end
      `CHK("steady level", 0, k)
    end
    setup(4'h9, pwm_timer_pkg::OUT_TOGGLE, pwm_timer_pkg::OUT_TOGGLE, 3'h1, 16'h1);
    repeat (4) @(posedge clk);
    `CHK("toggle a oe", 1'b1, oe_a)
    `CHK("toggle b oe", 1'b0, oe_b)
    measure(1'b1);
    `CHK("toggle high", 6, hi)
    `CHK("toggle period", 12, per)
    apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(4'h3, pwm_timer_pkg::OUT_TOGGLE, 2'h0, 3'h1, 1'b1));
    repeat (4) @(posedge clk);
    `CHK("toggle fixed top", 1'b0, oe_a)
    apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(4'h9, 2'h0, pwm_timer_pkg::OUT_NONINV, 3'h1, 1'b0));
    repeat (4) @(posedge clk);
    `CHK("direction input", 1'b0, oe_b)
    // count walk at a slow tick, started from a known zero
    setup(4'h9, 2'h0, pwm_timer_pkg::OUT_NONINV, 3'h0, 16'h1);
    // timer is stopped now, so this zero holds until the slow tick starts
    apb(1'b1, pwm_timer_pkg::OFF_COUNT, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFF_FLAGS, 32'hf);
    apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(4'h9, 2'h0, pwm_timer_pkg::OUT_NONINV, 3'h4, 1'b1));
    prev = 16'h0;
    for (int i = 0; i < 7; i++) begin
      k = 0;
      do begin
        apb(1'b0, pwm_timer_pkg::OFF_COUNT, 32'h0);
        k++;
      end while (rd[15:0] === prev && k < 200);
      prev = rd[15:0];
      `CHK("count step", seq[i], prev)
    end
    apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(4'h9, 2'h0, 2'h0, 3'h0, 1'b1));
    apb(1'b0, pwm_timer_pkg::OFF_FLAGS, 32'h0);
    `CHK("flags mode nine", 32'h7, rd)
    apb(1'b1, pwm_timer_pkg::OFF_FLAGS, 32'hf);
    apb(1'b0, pwm_timer_pkg::OFF_FLAGS, 32'h0);
    `CHK("flags cleared", 32'h0, rd)
    setup(4'h8, 2'h0, 2'h0, 3'h1, 16'h1);
    repeat (20) @(posedge clk);
    apb(1'b1, pwm_timer_pkg::OFF_CTRL, ctrl(4'h8, 2'h0, 2'h0, 3'h0, 1'b1));
    apb(1'b0, pwm_timer_pkg::OFF_FLAGS, 32'h0);
    `CHK("flags mode eight", 32'hf, rd)
    // reset in mid-run clears levels and registers
    rst_n <= 1'b0;
    @(posedge clk);
    `CHK("out_a mid reset", 1'b0, out_a)
    `CHK("out_b mid reset", 1'b0, out_b)
    rst_n <= 1'b1;
    apb(1'b0, pwm_timer_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl after mid reset", 32'h0, rd)
    give_verdict;
  end
endmodule

/* File: testbench/pin_load.sv */
// load model for one compare output pin
`timescale 1ns/1ps
module pin_load (
  input wire logic i_clk,
  input wire logic i_level,
  input wire logic i_oe,
  output logic o_pin
);
  logic float_val = 1'b0;
  // an undriven pin wanders every cycle so a stale level never looks valid
  always @(posedge i_clk) begin
    float_val <= i_oe ? ~i_level : ~float_val;
  end
  assign o_pin = i_oe ? i_level : float_val;
endmodule

/* File: verilog/compare_output_unit.sv */
// one compare output: waveform level and pin enable
`timescale 1ns/1ps
module compare_output_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_dual,
  input wire logic i_match,
  input wire logic i_up,
  input wire logic i_toggle_ok,
  input wire logic [1:0] i_mode,
  input wire logic i_pin_direction,
  output logic o_level,
  output logic o_oe
);

  logic connected;
  logic fire;
  logic next_level;

  assign connected = i_mode[1] || (i_mode == pwm_timer_pkg::OUT_TOGGLE && i_toggle_ok);
  assign fire = i_tick && i_dual && i_match;

  always_comb begin
    next_level = o_level;
    if (fire) begin
      unique case (i_mode)
        pwm_timer_pkg::OUT_TOGGLE: next_level = i_toggle_ok ? !o_level : o_level;
        pwm_timer_pkg::OUT_NONINV: next_level = !i_up;
        pwm_timer_pkg::OUT_INV: next_level = i_up;
        pwm_timer_pkg::OUT_OFF: next_level = o_level;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
      o_oe <= 1'b0;
    end else begin
      o_level <= next_level;
      o_oe <= i_pin_direction && connected;
    end
  end

endmodule

/* File: verilog/dual_slope_pwm_timer16.sv */
// dual-slope pwm timer with apb register access
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - phase correct sets overflow flag at bottom
// - phase correct top flag with top buffer load
// - phase correct loads compare buffers at top
// - fixed top modes mask written compare bits
// - output mode two non-inverted, three inverted
// - pin driven only when direction bit set
// - non-inverted clears upcounting, sets downcounting
// - frequency is clock over two n top
// - compare bottom gives low, top gives high
// - modes nine, eleven toggle a with a as top
// - modes eight, nine run frequency correct
// - top source by mode, one cycle at top
// - frequency correct loads and overflows at bottom
// - frequency correct sets top flag at top
// - compare flag set when count equals compare
// - counter synchronous, timer clock is enable
// - phase correct modes and their top sources
// - toggle only for a in modes 8-11
module dual_slope_pwm_timer16 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_compare_output_a,
  output logic o_compare_output_a_oe,
  output logic o_compare_output_b,
  output logic o_compare_output_b_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  pwm_timer_pkg::ctrl_t ctrl;
  pwm_timer_pkg::flags_t flags;
  pwm_timer_pkg::flags_t flag_set;
  logic [15:0] count_value;
  logic [15:0] compare_buffer_a;
  logic [15:0] compare_buffer_b;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value_reg;
  logic counting_down;
  logic timer_clock_enable;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  function automatic logic [15:0] fixed_top_of(input logic [3:0] mode);
    unique case (mode)
      pwm_timer_pkg::WAVE_PC_8BIT: fixed_top_of = pwm_timer_pkg::TOP_8BIT;
      pwm_timer_pkg::WAVE_PC_9BIT: fixed_top_of = pwm_timer_pkg::TOP_9BIT;
      pwm_timer_pkg::WAVE_PC_10BIT: fixed_top_of = pwm_timer_pkg::TOP_10BIT;
      default: fixed_top_of = 16'hffff;
    endcase
  endfunction

  wire [3:0] mode = ctrl.waveform_mode_field;
  wire fixed_mode = mode == pwm_timer_pkg::WAVE_PC_8BIT || mode == pwm_timer_pkg::WAVE_PC_9BIT
    || mode == pwm_timer_pkg::WAVE_PC_10BIT;
  wire cap_top = mode == pwm_timer_pkg::WAVE_PFC_CAP || mode == pwm_timer_pkg::WAVE_PC_CAP;
  wire cmpa_top = mode == pwm_timer_pkg::WAVE_PFC_CMPA || mode == pwm_timer_pkg::WAVE_PC_CMPA;
  wire pfc_mode = mode == pwm_timer_pkg::WAVE_PFC_CAP || mode == pwm_timer_pkg::WAVE_PFC_CMPA;
  wire pc_mode = fixed_mode || mode == pwm_timer_pkg::WAVE_PC_CAP
    || mode == pwm_timer_pkg::WAVE_PC_CMPA;
  wire dual = pfc_mode || pc_mode;
  wire toggle_ok_a = pfc_mode || cmpa_top || cap_top;
  wire [15:0] top = cap_top ? capture_value_reg : (cmpa_top ? compare_value_a : fixed_top_of(mode));
  wire [15:0] write_mask = fixed_mode ? fixed_top_of(mode) : 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  // counter events

  wire at_bottom = count_value == pwm_timer_pkg::COUNT_BOTTOM;
  wire at_top = count_value == top;
  // bottom counts as rising and top as falling so extreme compares hold a level
  wire up_eff = at_bottom || (!counting_down && !at_top);
  wire match_a = count_value == compare_value_a;
  wire match_b = count_value == compare_value_b;
  wire step = timer_clock_enable;
  wire load_top = step && pc_mode && at_top;
  wire load_bottom = step && pfc_mode && at_bottom;
  wire load_now = !dual || load_top || load_bottom;

  assign flag_set.counter_overflow_flag = step && dual && at_bottom;
  assign flag_set.compare_match_flag_a = step && (match_a || (dual && cmpa_top && at_top));
  assign flag_set.compare_match_flag_b = step && match_b;
  assign flag_set.capture_flag = step && dual && cap_top && at_top;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire access = i_psel && i_penable;
  wire take = access && o_pready;
  wire wr = take && i_pwrite;
  wire hit_ctrl = i_paddr == pwm_timer_pkg::OFF_CTRL;
  wire hit_count = i_paddr == pwm_timer_pkg::OFF_COUNT;
  wire hit_cmp_a = i_paddr == pwm_timer_pkg::OFF_CMP_A;
  wire hit_cmp_b = i_paddr == pwm_timer_pkg::OFF_CMP_B;
  wire hit_capture = i_paddr == pwm_timer_pkg::OFF_CAPTURE;
  wire hit_flags = i_paddr == pwm_timer_pkg::OFF_FLAGS;
  wire mapped = hit_ctrl || hit_count || hit_cmp_a || hit_cmp_b || hit_capture || hit_flags;
  wire [15:0] wdata_masked = i_pwdata[15:0] & write_mask;
  wire [3:0] flag_clear = (wr && hit_flags) ? i_pwdata[3:0] : 4'h0;

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) next_rdata = {19'h0, ctrl};
    if (hit_count) next_rdata = {16'h0, count_value};
    if (hit_cmp_a) next_rdata = {16'h0, compare_buffer_a};
    if (hit_cmp_b) next_rdata = {16'h0, compare_buffer_b};
    if (hit_capture) next_rdata = {16'h0, capture_value_reg};
    if (hit_flags) next_rdata = {28'h0, flags};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= access && !o_pready;
      o_pslverr <= access && !o_pready && !mapped;
      o_prdata <= (access && !o_pready && !i_pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= pwm_timer_pkg::CTRL_RESET;
      capture_value_reg <= pwm_timer_pkg::VALUE_RESET;
      compare_buffer_a <= pwm_timer_pkg::VALUE_RESET;
      compare_buffer_b <= pwm_timer_pkg::VALUE_RESET;
    end else begin
      if (wr && hit_ctrl) ctrl <= i_pwdata[12:0];
      if (wr && hit_capture) capture_value_reg <= i_pwdata[15:0];
      if (wr && hit_cmp_a) compare_buffer_a <= wdata_masked;
      if (wr && hit_cmp_b) compare_buffer_b <= wdata_masked;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      compare_value_a <= pwm_timer_pkg::VALUE_RESET;
      compare_value_b <= pwm_timer_pkg::VALUE_RESET;
    end else if (load_now) begin
      compare_value_a <= compare_buffer_a;
      compare_value_b <= compare_buffer_b;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= pwm_timer_pkg::FLAGS_RESET;
    end else begin
      flags <= (flags & ~flag_clear) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  logic [15:0] next_count;
  logic next_down;
  always_comb begin
    next_count = count_value;
    next_down = counting_down;
    if (step) begin
      if (!dual) begin
        next_count = count_value + 16'h0001;
        next_down = 1'b0;
      end else if (at_top && !at_bottom) begin
        next_count = count_value - 16'h0001;
        next_down = 1'b1;
      end else if (at_bottom) begin
        next_count = count_value + 16'h0001;
        next_down = 1'b0;
      end else begin
        next_count = counting_down ? count_value - 16'h0001 : count_value + 16'h0001;
      end
    end
    if (wr && hit_count) next_count = i_pwdata[15:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_value <= pwm_timer_pkg::VALUE_RESET;
      counting_down <= 1'b0;
    end else begin
      count_value <= next_count;
      counting_down <= next_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and outputs

  timer_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clock_select(ctrl.clock_select),
    .o_tick(timer_clock_enable)
  );

  compare_output_unit u_out_a (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(step),
    .i_dual(dual),
    .i_match(match_a),
    .i_up(up_eff),
    .i_toggle_ok(toggle_ok_a),
    .i_mode(ctrl.output_mode_field_a),
    .i_pin_direction(ctrl.pin_direction_a),
    .o_level(o_compare_output_a),
    .o_oe(o_compare_output_a_oe)
  );

  compare_output_unit u_out_b (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(step),
    .i_dual(dual),
    .i_match(match_b),
    .i_up(up_eff),
    .i_toggle_ok(1'b0),
    .i_mode(ctrl.output_mode_field_b),
    .i_pin_direction(ctrl.pin_direction_b),
    .o_level(o_compare_output_b),
    .o_oe(o_compare_output_b_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  overflow_at_bottom_a: assert property (step && dual && at_bottom |=> flags.counter_overflow_flag)
    else $error("overflow flag not set at bottom");
  top_reverse_a: assert property (step && dual && at_top && !at_bottom && !(wr && hit_count)
    |=> counting_down && count_value == $past(count_value) - 16'h0001)
    else $error("counter did not reverse at top");
  pc_top_load_a: assert property (step && pc_mode && at_top |=> compare_value_a == $past(compare_buffer_a))
    else $error("buffer not loaded at top");
  pfc_hold_a: assert property (dual && pfc_mode && !at_bottom && $stable(ctrl) |=> $stable(compare_value_a))
    else $error("compare changed away from bottom");
  capture_flag_a: assert property (step && dual && cap_top && at_top |=> flags.capture_flag)
    else $error("capture flag not set at top");
  fixed_mask_a: assert property (wr && hit_cmp_a && fixed_mode |=> (compare_buffer_a & ~$past(write_mask)) == 16'h0)
    else $error("masked bits kept");
  noninv_clear_a: assert property (step && dual && match_a && up_eff
    && ctrl.output_mode_field_a == pwm_timer_pkg::OUT_NONINV |=> !o_compare_output_a)
    else $error("non-inverted output not cleared upcounting");
  pin_enable_a: assert property (!ctrl.pin_direction_a |=> !o_compare_output_a_oe)
    else $error("pin driven without direction");
  tick_every_a: assert property (ctrl.clock_select == 3'h1 |-> timer_clock_enable)
    else $error("divide by one missing a tick");
  compare_flag_a: assert property (step && match_b |=> flags.compare_match_flag_b)
    else $error("compare b flag not set");
  apb_answer_a: assert property (access && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer timing wrong");
  inv_set_a: assert property (step && dual && match_b && up_eff
    && ctrl.output_mode_field_b == pwm_timer_pkg::OUT_INV |=> o_compare_output_b)
    else $error("inverted output not set upcounting");
  noninv_set_a: assert property (step && dual && match_b && !up_eff
    && ctrl.output_mode_field_b == pwm_timer_pkg::OUT_NONINV |=> o_compare_output_b)
    else $error("non-inverted output not set downcounting");
  pfc_top_flag_a: assert property (step && pfc_mode && cmpa_top && at_top |=> flags.compare_match_flag_a)
    else $error("compare a flag not set at top");
  toggle_b_off_a: assert property (ctrl.output_mode_field_b == pwm_timer_pkg::OUT_TOGGLE |=> !o_compare_output_b_oe)
    else $error("toggle mode drove output b");
  pfc_bottom_load_a: assert property (load_bottom |=> compare_value_b == $past(compare_buffer_b))
    else $error("buffer b not loaded at bottom");
  toggle_flip_a: assert property (step && match_a && toggle_ok_a
    && ctrl.output_mode_field_a == pwm_timer_pkg::OUT_TOGGLE |=> o_compare_output_a != $past(o_compare_output_a))
    else $error("toggle output did not flip");
  pin_enable_b_a: assert property (!ctrl.pin_direction_b |=> !o_compare_output_b_oe)
    else $error("pin b driven without direction");

  cover_overflow_c: cover property (flag_set.counter_overflow_flag);
  cover_reverse_c: cover property (step && dual && at_top ##1 counting_down);
  cover_toggle_c: cover property (step && match_a && ctrl.output_mode_field_a == pwm_timer_pkg::OUT_TOGGLE
    && toggle_ok_a);
  cover_pfc_load_c: cover property (load_bottom && compare_buffer_a != compare_value_a);

endmodule

/* File: verilog/pwm_timer_pkg.sv */
// constants and carrier types for the dual-slope 16-bit pwm timer
package pwm_timer_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_CMP_A = 8'h08;
  localparam logic [7:0] OFF_CMP_B = 8'h0c;
  localparam logic [7:0] OFF_CAPTURE = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;

  // waveform mode field encodings
  localparam logic [3:0] WAVE_PC_8BIT = 4'h1;
  localparam logic [3:0] WAVE_PC_9BIT = 4'h2;
  localparam logic [3:0] WAVE_PC_10BIT = 4'h3;
  localparam logic [3:0] WAVE_PFC_CAP = 4'h8;
  localparam logic [3:0] WAVE_PFC_CMPA = 4'h9;
  localparam logic [3:0] WAVE_PC_CAP = 4'ha;
  localparam logic [3:0] WAVE_PC_CMPA = 4'hb;

  // fixed top values and counter limits
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

  // output mode field encodings
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_NONINV = 2'h2;
  localparam logic [1:0] OUT_INV = 2'h3;

  // prescale divisors selected by the clock select field
  localparam logic [10:0] DIV_1 = 11'h001;
  localparam logic [10:0] DIV_8 = 11'h008;
  localparam logic [10:0] DIV_64 = 11'h040;
  localparam logic [10:0] DIV_256 = 11'h100;
  localparam logic [10:0] DIV_1024 = 11'h400;

  typedef struct packed {
    logic pin_direction_b;
    logic pin_direction_a;
    logic [2:0] clock_select;
    logic [1:0] output_mode_field_b;
    logic [1:0] output_mode_field_a;
    logic [3:0] waveform_mode_field;
  } ctrl_t;

  typedef struct packed {
    logic capture_flag;
    logic compare_match_flag_b;
    logic compare_match_flag_a;
    logic counter_overflow_flag;
  } flags_t;

  localparam ctrl_t CTRL_RESET = '0;
  localparam flags_t FLAGS_RESET = '0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

endpackage

/* File: verilog/timer_prescaler.sv */
// prescaler that pulses the timer clock enable once every n clock cycles
`timescale 1ns/1ps
module timer_prescaler (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_clock_select,
  output logic o_tick
);

  logic [10:0] div_count;
  logic [10:0] divisor;

  function automatic logic [10:0] divisor_of(input logic [2:0] sel);
    unique case (sel)
      3'h1: divisor_of = pwm_timer_pkg::DIV_1;
      3'h2: divisor_of = pwm_timer_pkg::DIV_8;
      3'h3: divisor_of = pwm_timer_pkg::DIV_64;
      3'h4: divisor_of = pwm_timer_pkg::DIV_256;
      3'h5: divisor_of = pwm_timer_pkg::DIV_1024;
      default: divisor_of = 11'h000;
    endcase
  endfunction

  assign divisor = divisor_of(i_clock_select);
  // a zero divisor means the timer is stopped
  assign o_tick = (divisor != 11'h000) && (div_count >= divisor - 11'h001);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_count <= 11'h000;
    end else if (o_tick || divisor == 11'h000) begin
      div_count <= 11'h000;
    end else begin
      div_count <= div_count + 11'h001;
    end
  end

endmodule
